/* File: pkg/ssc_pkg.sv */
// Purpose: Constants for the host-side sleep and write sequencer of an async SRAM
// Assumes: 40 MHz clock, 25 ns period
// Notes: Times are kept in their own unit, cycle counts derived from the clock period
package ssc_pkg;
	localparam int CLK_PERIOD_PS = 25000; // Clock period in picoseconds
	localparam int DESELECT_TO_SLEEP_GAP_NS = 100; // Least deselect before sleep request
	localparam int SLEEP_ENTRY_TIME_MS = 1; // Longest entry into deep sleep
	localparam int WAKE_TO_SELECT_GAP_MS = 1; // Least wait after wake before select
	localparam int SUPPLY_SETTLE_TIME_US = 100; // Least wait from stable supply to access
	localparam int STROBE_TO_FLOAT_TIME_PS = 8000; // Slow grade, covers fast grade too
	localparam int INPUT_SETUP_TIME_PS = 8000; // Slow grade, covers fast grade too
	// Least times round up to whole cycles
	localparam int DESEL_CYC = (DESELECT_TO_SLEEP_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ENTRY_CYC = (SLEEP_ENTRY_TIME_MS * 1000000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WAKE_CYC = (WAKE_TO_SELECT_GAP_MS * 1000000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int POWER_CYC = (SUPPLY_SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WPULSE_RAW = (STROBE_TO_FLOAT_TIME_PS + INPUT_SETUP_TIME_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WPULSE_CYC = (WPULSE_RAW < 1) ? 1 : WPULSE_RAW;
	localparam int CNT_W = 20; // Width of the wait counter
	localparam int ADDR_W = 20; // Address width
	localparam int DATA_W = 16; // Data width
endpackage

/* File: verilog/ssc_wait_timer.sv */
`timescale 1ns/1ps
// Purpose: Loadable down-counter used for every wait of the sequencer
// Assumes: One clock, asynchronous active-high reset
// Notes: done is high while the count is zero
module ssc_wait_timer #(
	parameter int W = 20
) (
	input wire logic clk, // Clock
	input wire logic rst, // Asynchronous reset
	input wire logic load, // Load pulse
	input wire logic [W-1:0] value, // Cycles to wait
	output logic done // Count has run out
);
	logic [W-1:0] cnt_q; // Remaining cycles
	logic [W-1:0] cnt_d; // Next count
	// Load wins over counting down
	assign cnt_d = load ? value : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	assign done = (cnt_q == '0);
	// Counter register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule

/* File: verilog/ssc_host.sv */
`timescale 1ns/1ps
// Purpose: Host controller that drives an async SRAM with deep sleep through its pins
// Assumes: Pins synchronous to clk; one access at a time
// Notes: Reads take one settle cycle plus the write-pulse count; long waits are parameters

// Contract
// R1 - Deselect at least 100 ns before sleep
// R2 - Memory sleeps within 1 ms of request
// R3 - Wait 1 ms after wake before select
// R4 - Hold all lines static during entry
// R5 - Sleep request high during every access
// R6 - Wait 100 us after power before access
// R7 - Select active only select_one low, two high
// R8 - Write needs strobe, select, lane low
// R9 - First rising edge ends the write
// R10 - Write pulse at least float plus setup
// R11 - Sleeping memory floats all data lines
// R12 - Never request sleep while selected
// R13 - Correction flag valid only during reads
// R14 - Data floats when deselected or gated
// R15 - Sequence sleep with counted waits
// R16 - No access until wake gap expires
module ssc_host #(
	parameter int POWER_WAIT = ssc_pkg::POWER_CYC, // Power-up wait cycles
	parameter int ENTRY_WAIT = ssc_pkg::ENTRY_CYC, // Sleep entry wait cycles
	parameter int WAKE_WAIT = ssc_pkg::WAKE_CYC // Wake-to-select wait cycles
) (
	input wire logic clk, // Clock, 40 MHz
	input wire logic rst, // Asynchronous reset
	input wire logic req_valid, // Access request
	input wire logic req_write, // 1 write, 0 read
	input wire logic [ssc_pkg::ADDR_W-1:0] req_addr, // Word address
	input wire logic [ssc_pkg::DATA_W-1:0] req_wdata, // Write data
	input wire logic [1:0] req_lanes, // Lane enables, bit1 upper
	input wire logic sleep_cmd, // Level: 1 asks for deep sleep
	output logic req_ready, // Idle and awake, request taken unless sleep_cmd is high
	output logic done, // Access finished pulse
	output logic [ssc_pkg::DATA_W-1:0] rdata, // Read data
	output logic rd_corrected, // Read had a corrected error
	output logic asleep, // Memory is in deep sleep
	output logic sleep_request_n, // Sleep pin
	output logic select_one_n, // Select one pin
	output logic select_two, // Select two pin
	output logic write_strobe_n, // Write strobe pin
	output logic output_gate_n, // Output gate pin
	output logic upper_byte_lane_n, // Upper lane pin
	output logic low_byte_lane_n, // Lower lane pin
	output logic [ssc_pkg::ADDR_W-1:0] addr, // Address pins
	input wire logic [ssc_pkg::DATA_W-1:0] dq_i, // Data pins in
	output logic [ssc_pkg::DATA_W-1:0] dq_o, // Data pins out
	output logic dq_oe, // Host drives data
	input wire logic ecc_fix_flag // Correction flag from memory
);
	typedef enum logic [7:0] {
		S_POWER = 8'h01, // Supply settle wait
		S_IDLE = 8'h02, // Awake, deselected
		S_ACC = 8'h04, // Strobe or gate low
		S_END = 8'h08, // Terminating edge
		S_DESEL = 8'h10, // Deselect gap before sleep
		S_ENTRY = 8'h20, // Sleep entry, lines static
		S_SLEEP = 8'h40, // In deep sleep
		S_WAKE = 8'h80 // Wake-to-select gap
	} ssc_state_t;

	ssc_state_t st_q, st_d; // Sequencer state
	logic tload; // Timer load pulse
	logic [ssc_pkg::CNT_W-1:0] tval; // Timer load value
	logic tdone; // Timer ran out
	logic wr_q; // Current access is a write
	logic take; // Request accepted this cycle
	logic sel_q; // Host-side select level
	logic pwr_armed_q; // Power wait has been loaded
	logic tload_all; // Combined load, power arm or state load
	logic [ssc_pkg::CNT_W-1:0] tval_all; // Combined value

	// One timer serves every wait; each waiting state loads it on entry
	// The power wait reaches it only through the combined load
	ssc_wait_timer #(.W(ssc_pkg::CNT_W)) u_timer (
		.clk(clk),
		.rst(rst),
		.load(tload_all),
		.value(tval_all),
		.done(tdone)
	);

	assign take = (st_q == S_IDLE) && req_valid && !sleep_cmd; // [R16]

	// Next state and timer loads
	always_comb
	begin
		st_d = st_q;
		tload = 1'b0;
		tval = '0;
		unique case (st_q)
			S_POWER:
				if (tdone)
					st_d = S_IDLE; // [R6]
			S_IDLE:
				if (sleep_cmd)
				begin
					// Select is already high here; count the gap from now
					st_d = S_DESEL;
					tload = 1'b1;
					tval = ssc_pkg::CNT_W'(ssc_pkg::DESEL_CYC); // [R1] [R15]
				end
				else if (take)
				begin
					st_d = S_ACC;
					tload = 1'b1;
					tval = ssc_pkg::CNT_W'(ssc_pkg::WPULSE_CYC); // [R10]
				end
			S_ACC:
				if (tdone)
					st_d = S_END;
			S_END:
				st_d = S_IDLE;
			S_DESEL:
				if (tdone)
				begin
					st_d = S_ENTRY;
					tload = 1'b1;
					tval = ssc_pkg::CNT_W'(ENTRY_WAIT); // [R2]
				end
			S_ENTRY:
				if (tdone)
					st_d = S_SLEEP; // [R4]
			S_SLEEP:
				if (!sleep_cmd)
				begin
					st_d = S_WAKE;
					tload = 1'b1;
					tval = ssc_pkg::CNT_W'(WAKE_WAIT); // [R3]
				end
			S_WAKE:
				if (tdone)
					st_d = S_IDLE; // [R16]
			default:
				st_d = S_IDLE;
		endcase
		// Power wait is loaded by reset release below through !pwr_armed_q
		if (st_q == S_POWER && tdone && st_d == S_POWER)
			tload = 1'b0;
	end

	// Power-up timer arms on the first cycle after reset
	assign tload_all = tload || !pwr_armed_q;
	assign tval_all = pwr_armed_q ? tval : ssc_pkg::CNT_W'(POWER_WAIT);

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= S_POWER;
		else if (!pwr_armed_q)
			st_q <= S_POWER; // Hold until the timer is armed
		else
			st_q <= st_d;
	end

	// Arm flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pwr_armed_q <= 1'b0;
		else
			pwr_armed_q <= 1'b1;
	end

	// Pin drive: select is low-active one, two stays high when selected
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sleep_request_n <= 1'b1;
			sel_q <= 1'b0;
			select_one_n <= 1'b1;
			select_two <= 1'b0;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			upper_byte_lane_n <= 1'b1;
			low_byte_lane_n <= 1'b1;
			addr <= '0;
			dq_o <= '0;
			dq_oe <= 1'b0;
			wr_q <= 1'b0;
		end
		else if (take)
		begin
			// Sleep pin stays high for the whole access
			sleep_request_n <= 1'b1; // [R5]
			sel_q <= 1'b1;
			select_one_n <= 1'b0; // [R7]
			select_two <= 1'b1; // [R7]
			write_strobe_n <= !req_write; // [R8]
			output_gate_n <= req_write;
			upper_byte_lane_n <= !req_lanes[1]; // [R8]
			low_byte_lane_n <= !req_lanes[0];
			addr <= req_addr;
			dq_o <= req_wdata;
			dq_oe <= req_write;
			wr_q <= req_write;
		end
		else if (st_q == S_ACC && tdone)
		begin
			// Strobe rises first; select, lanes and data still held [R9]
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
		end
		else if (st_q == S_END)
		begin
			sel_q <= 1'b0;
			select_one_n <= 1'b1;
			select_two <= 1'b0;
			upper_byte_lane_n <= 1'b1;
			low_byte_lane_n <= 1'b1;
			dq_oe <= 1'b0; // Data hold of zero met one cycle after strobe
		end
		else if (st_d == S_ENTRY && st_q == S_DESEL && !sel_q)
			sleep_request_n <= 1'b0; // [R12] [R1]
		else if (st_q == S_SLEEP && !sleep_cmd)
			sleep_request_n <= 1'b1; // [R3]
	end

	// Read capture at the end of the gate pulse; flag only sampled on reads
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata <= '0;
			rd_corrected <= 1'b0;
		end
		else if (st_q == S_ACC && tdone && !wr_q)
		begin
			rdata <= dq_i;
			rd_corrected <= ecc_fix_flag; // [R13]
		end
	end

	// Handshake and status outputs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			req_ready <= 1'b0;
			done <= 1'b0;
			asleep <= 1'b0;
		end
		else
		begin
			// Before the power wait is armed the idle timer looks done; keep ready low [R6]
			req_ready <= pwr_armed_q && (st_d == S_IDLE) && !(st_q == S_IDLE && take);
			done <= (st_q == S_END);
			asleep <= (st_d == S_SLEEP); // [R11]
		end
	end
endmodule

/* File: verification/ssc_host_chk.sv */
// Purpose: Pin checks for the SRAM host sequencer
// Assumes: One clock, async high reset
// Notes: Gap counters saturate so they never wrap
`timescale 1ns/1ps
module ssc_host_chk #(
	parameter int POWER_WAIT = 8, // Power wait
	parameter int WAKE_WAIT = 8 // Wake gap
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic sleep_request_n, // Sleep
	input wire logic select_one_n, // Select one
	input wire logic select_two, // Select two
	input wire logic write_strobe_n, // Strobe
	input wire logic output_gate_n, // Gate
	input wire logic upper_byte_lane_n, // Upper lane
	input wire logic low_byte_lane_n, // Low lane
	input wire logic [ssc_pkg::ADDR_W-1:0] addr, // Address
	input wire logic [ssc_pkg::DATA_W-1:0] dq_o, // Data
	input wire logic dq_oe // Drive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire cs_on = !select_one_n && select_two; // Effective select
	wire lane_on = !upper_byte_lane_n || !low_byte_lane_n; // Any lane
	logic [7:0] off_q; // Deselected cycles
	logic [15:0] up_q; // Awake cycles
	// Both restart at reset, so power and wake gaps share one count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			off_q <= 8'h00;
			up_q <= 16'h0000;
		end
		else
		begin
			off_q <= cs_on ? 8'h00 : off_q + {7'h00, off_q != 8'hFF};
			up_q <= !sleep_request_n ? 16'h0000 : up_q + {15'h0000, up_q != 16'hFFFF};
		end
	end
	sleep_excl_a: assert property (!sleep_request_n |-> !cs_on)
		else $error("sleep while selected");
	desel_gap_a: assert property ($fell(sleep_request_n) |-> off_q >= ssc_pkg::DESEL_CYC)
		else $error("deselect gap short");
	wake_gap_a: assert property ($rose(cs_on) |-> up_q >= WAKE_WAIT)
		else $error("wake gap short");
	power_gap_a: assert property ($rose(cs_on) |-> up_q >= POWER_WAIT)
		else $error("power wait short");
	entry_still_a: assert property (!sleep_request_n && !$past(sleep_request_n)
		|-> $stable({addr, dq_o, dq_oe, select_one_n, write_strobe_n, lane_on}))
		else $error("lines moved in sleep");
	access_awake_a: assert property (!write_strobe_n || !output_gate_n
		|-> sleep_request_n && cs_on)
		else $error("access not awake");
	write_lane_a: assert property (!write_strobe_n |-> lane_on && dq_oe)
		else $error("write without lane");
	pulse_width_a: assert property ($fell(write_strobe_n) |=> !write_strobe_n)
		else $error("strobe too short");
	write_end_a: assert property ($rose(write_strobe_n) |-> cs_on && lane_on && $stable(dq_o))
		else $error("write end not strobe");
	no_fight_a: assert property (dq_oe |-> output_gate_n)
		else $error("drive with gate low");
	cover property ($rose(write_strobe_n));
	cover property ($fell(sleep_request_n));
	cover property ($rose(sleep_request_n));
endmodule
bind ssc_host ssc_host_chk #(.POWER_WAIT(POWER_WAIT), .WAKE_WAIT(WAKE_WAIT)) ssc_host_chk_i (
	.clk, .rst, .sleep_request_n, .select_one_n, .select_two, .write_strobe_n, .output_gate_n,
	.upper_byte_lane_n, .low_byte_lane_n, .addr, .dq_o, .dq_oe);

/* File: verification/ssc_sram_model.sv */
// Purpose: Behavioural async SRAM with deep sleep
// Assumes: clk only paces the float pattern
// Notes: Sleep is entered at once, well inside the limit
`timescale 1ns/1ps
module ssc_sram_model (
	input wire logic clk, // Pattern pace
	input wire logic sleep_request_n, // Sleep
	input wire logic select_one_n, // Select one
	input wire logic select_two, // Select two
	input wire logic write_strobe_n, // Strobe
	input wire logic output_gate_n, // Gate
	input wire logic upper_byte_lane_n, // Upper lane
	input wire logic low_byte_lane_n, // Low lane
	input wire logic [ssc_pkg::ADDR_W-1:0] addr, // Address
	input wire logic [ssc_pkg::DATA_W-1:0] dq_o, // Host data
	input wire logic inj_err, // Corrected read
	output logic [ssc_pkg::DATA_W-1:0] dq_i, // Read data
	output logic ecc_fix_flag // Flag
);
	logic [15:0] mem [int]; // Storage
	logic [15:0] word; // Word at addr
	logic flt_q = 1'b0; // Float phase
	wire cs = !select_one_n && select_two;
	wire awake = sleep_request_n;
	wire wr_on = awake && cs && !write_strobe_n && (!upper_byte_lane_n || !low_byte_lane_n);
	wire rd_on = awake && cs && !output_gate_n && write_strobe_n;
	// A released line must never look like held data
	always @(posedge clk) flt_q <= ~flt_q;
	// First closing edge commits the enabled lanes
	always @(negedge wr_on)
	begin
		if (!mem.exists(int'(addr))) mem[int'(addr)] = 16'h0000;
		if (!low_byte_lane_n) mem[int'(addr)][7:0] = dq_o[7:0];
		if (!upper_byte_lane_n) mem[int'(addr)][15:8] = dq_o[15:8];
	end
	// Unselected lanes float
	always @*
	begin
		word = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'h0000;
		dq_i = {16{flt_q}} ^ 16'hA5A5;
		ecc_fix_flag = ~flt_q;
		if (rd_on && !low_byte_lane_n) dq_i[7:0] = word[7:0];
		if (rd_on && !upper_byte_lane_n) dq_i[15:8] = word[15:8];
		if (rd_on) ecc_fix_flag = inj_err;
	end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the SRAM host sequencer
// Assumes: Power, entry and wake waits shortened to 8 cycles
// Notes: Random words from a fixed-seed LFSR
`timescale 1ns/1ps
module tb;
	localparam int W8 = 8; // Sim wait
	logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, sleep_cmd = 1'b0;
	logic inj_err = 1'b0, req_ready, done, rd_corrected, asleep, sleep_request_n, select_one_n;
	logic select_two, write_strobe_n, output_gate_n, upper_byte_lane_n, low_byte_lane_n, dq_oe;
	logic ecc_fix_flag;
	logic [19:0] req_addr = 20'h00000, addr;
	logic [15:0] req_wdata = 16'h0000, rdata, dq_o, dq_i;
	logic [1:0] req_lanes = 2'h3, l;
	logic [15:0] exp_q [8]; // Expected words
	logic [31:0] seed = 32'h00016642; // LFSR state
	int errors = 0, cmp_count = 0, n;
	always #12.5 clk = ~clk;
	ssc_host #(.POWER_WAIT(W8), .ENTRY_WAIT(W8), .WAKE_WAIT(W8)) ssc_host_i (.clk, .rst,
		.req_valid, .req_write, .req_addr, .req_wdata, .req_lanes, .sleep_cmd, .req_ready, .done,
		.rdata, .rd_corrected, .asleep, .sleep_request_n, .select_one_n, .select_two,
		.write_strobe_n, .output_gate_n, .upper_byte_lane_n, .low_byte_lane_n, .addr, .dq_i,
		.dq_o, .dq_oe, .ecc_fix_flag);
	ssc_sram_model ssc_sram_model_i (.clk, .sleep_request_n, .select_one_n, .select_two,
		.write_strobe_n, .output_gate_n, .upper_byte_lane_n, .low_byte_lane_n, .addr, .dq_o,
		.inj_err, .dq_i, .ecc_fix_flag);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] m);
		return {m[1] ? d[15:8] : o[15:8], m[0] ? d[7:0] : o[7:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Waits for ready, requests at an edge, drops at the taking edge
	task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] m);
		n = 0;
		@(posedge clk);
		while (req_ready !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_lanes <= m;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		chk(16'(n < 20), 16'h0001);
	endtask
	task automatic wrap_up();
		$display("errors %0d cmp_count %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		chk(16'({sleep_request_n, select_one_n, select_two, write_strobe_n, dq_oe}), 16'h001A);
		rst <= 1'b0;
		n = 0;
		while (req_ready !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		chk(16'(n >= W8 - 1), 16'h0001);
		for (int i = 0; i < 20; i++)
		begin
			seed = lfsr(seed);
			l = (i < 8 || seed[17:16] == 2'h0) ? 2'h3 : seed[17:16];
			n = (i < 8) ? i : int'(seed[20:18]);
			exp_q[n] = merge((i < 8) ? 16'h0000 : exp_q[n], seed[15:0], l);
			acc(1'b1, 20'(n), seed[15:0], l);
		end
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			inj_err <= seed[0];
			acc(1'b0, 20'(i), 16'h0000, 2'h3);
			chk(rdata, exp_q[i]);
			chk(16'(rd_corrected), 16'(seed[0]));
		end
		// Request held during sleep must be refused
		sleep_cmd <= 1'b1;
		req_valid <= 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		chk(16'({asleep, sleep_request_n, select_one_n, req_ready, done}), 16'h0014);
		req_valid <= 1'b0;
		sleep_cmd <= 1'b0;
		n = 0;
		while (req_ready !== 1'b1 && n < 99)
		begin
			@(posedge clk);
			n++;
		end
		chk(16'(n >= W8), 16'h0001);
		acc(1'b1, 20'h00005, 16'h5A3C, 2'h3);
		acc(1'b0, 20'h00005, 16'h0000, 2'h3);
		chk(rdata, 16'h5A3C);
		wrap_up();
	end
	initial
	begin
		#100000;
		errors++;
		wrap_up();
	end
endmodule
